//--- rtl/sbf_ops_pkg.sv
/*
  Constants and carrier types for the short branch and status set group.
  Assumes one 20 MHz clock and a synchronous, active-low reset.
*/
// Operation
// - Opcode high byte 1110 11xx is fast branch in object code mode.
// - Branch offset is signed 8-bit, -128 to +127.
// - Conditions: zero set, zero clear, test set/clear.
// - Taken adds offset, else PC plus one.
// - Fast branch always takes four cycles.
// - Group clears repeat count, runs exactly once.
// - Aux subtract removes zero-extended immediate, one cycle.
// - Aux pointer picks one of eight registers.
// - Status set ORs mask into status bits.
// - Mask bits map to both status words.
// - Two cycles when interrupt or debug mask set.
// - Object mode set opcode, five cycles.
// - External flag set drives pin high, one cycle.
package sbf_ops_pkg;
  localparam int PC_W = 22;
  localparam int AUX_W = 32;
  localparam int AUX_N = 8;
  localparam int MEM_ADDR_W = 11;
  localparam int BLOCK_BIT = 10;
  localparam int CNT_W = 3;
  localparam logic [7:0] OFS_OPCODE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ST0 = 8'h08;
  localparam logic [7:0] OFS_ST1 = 8'h0C;
  localparam logic [7:0] OFS_PC = 8'h10;
  localparam logic [7:0] OFS_REPEAT = 8'h14;
  localparam logic [7:0] OFS_CYCLES = 8'h18;
  localparam logic [7:0] OFS_AUX_BASE = 8'h20;
  localparam logic [7:0] OFS_AUX_LAST = 8'h3C;
  localparam logic [7:0] SBF_HI = 8'hEC;
  localparam logic [7:0] SBF_MASK = 8'hFC;
  localparam logic [7:0] AUX_REG_SUBTRACT_OP_HI = 8'hFD;
  localparam logic [7:0] SET_STATUS_BITS_OP_HI = 8'h3B;
  localparam logic [15:0] OP_SET_BLOCK_MAP = 16'h561A;
  localparam logic [15:0] OP_SET_OBJ_MODE = 16'h561F;
  localparam logic [15:0] OP_SET_EXT_FLAG = 16'h5626;
  localparam logic [1:0] COND_EQUAL = 2'h0;
  localparam logic [1:0] COND_NOT_EQUAL = 2'h1;
  localparam logic [1:0] COND_TEST_SET = 2'h2;
  localparam logic [1:0] COND_TEST_CLEAR = 2'h3;
  localparam logic [CNT_W-1:0] CYC_SBF = 3'h4;
  localparam logic [CNT_W-1:0] CYC_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CYC_TWO = 3'h2;
  localparam logic [CNT_W-1:0] CYC_MODE = 3'h5;
  localparam int MASK_GLOBAL_IRQ_MASK = 4;
  localparam int MASK_DEBUG_EVENT_MASK = 5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_READ = 3'b100
  } fsm_t;

  // Low four bits line up with mask bits 0 to 3.
  typedef struct packed {
    logic zero_flag;
    logic carry_flag;
    logic test_flag;
    logic overflow_saturate_mode;
    logic sign_extend_mode;
  } status_word_zero_t;

  // Low four bits line up with mask bits 4 to 7.
  typedef struct packed {
    logic [2:0] aux_pointer_select;
    logic external_flag_output;
    logic block_map_select;
    logic object_code_mode;
    logic vector_map_select;
    logic page_mode_select;
    logic debug_event_mask;
    logic global_irq_mask;
  } status_word_one_t;

  typedef struct packed {
    fsm_t fsm;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] last_cycles;
    logic decode_miss;
    logic last_taken;
    logic mem_block_b;
    status_word_zero_t st0;
    status_word_one_t st1;
    logic [PC_W-1:0] pc;
    logic [15:0] repeat_count;
    logic [AUX_N-1:0][AUX_W-1:0] aux_register;
    logic [31:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{fsm: ST_IDLE, default: '0};
endpackage : sbf_ops_pkg

//--- rtl/short_branch_and_status_set_ops.sv
/*
  Decode and execute logic for the fast short branch, auxiliary subtract,
  masked status set and single-bit mode sets, with the CPU status words,
  program counter, repeat count and auxiliary registers behind an
  Avalon-MM slave with waitrequest.
  Assumes a master that holds each request until waitrequest is low.
*/
`timescale 1ns/1ps
module short_branch_and_status_set_ops (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic EXT_FLAG_OUT,
  input wire logic [sbf_ops_pkg::MEM_ADDR_W-1:0] MEM_ADDR,
  input wire logic MEM_IS_PROG,
  output logic MEM_BLOCK_B
);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------

  function automatic logic [31:0] merge_be(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  function automatic logic [sbf_ops_pkg::PC_W-1:0] sext_offset(
    input logic [7:0] off
  );
    return {{(sbf_ops_pkg::PC_W-8){off[7]}}, off};
  endfunction : sext_offset

  function automatic logic [2:0] aux_index(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - sbf_ops_pkg::OFS_AUX_BASE;
    return rel[4:2];
  endfunction : aux_index

  function automatic logic is_aux_addr(input logic [7:0] addr);
    return addr >= sbf_ops_pkg::OFS_AUX_BASE &&
           addr <= sbf_ops_pkg::OFS_AUX_LAST &&
           addr[1:0] == 2'b00;
  endfunction : is_aux_addr

  // With the map bit clear, program space sees the two blocks swapped.
  function automatic logic block_b_sel(
    input logic [sbf_ops_pkg::MEM_ADDR_W-1:0] addr,
    input logic prog,
    input logic map_bit
  );
    logic upper;
    upper = addr[sbf_ops_pkg::BLOCK_BIT];
    if (prog && !map_bit) begin
      return !upper;
    end
    return upper;
  endfunction : block_b_sel

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------

  sbf_ops_pkg::state_t s;
  sbf_ops_pkg::state_t next_s;
  logic wait_req;
  logic [31:0] read_val;
  logic [15:0] opcode;
  logic [7:0] op_hi;
  logic [7:0] op_lo;
  logic cond_true;
  logic [sbf_ops_pkg::CNT_W-1:0] cycles;
  logic [31:0] wr_merged;

  assign opcode = AVS_WRITEDATA[15:0];
  assign op_hi = opcode[15:8];
  assign op_lo = opcode[7:0];

  // --------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------

  always_comb begin
    read_val = '0;
    case (AVS_ADDRESS)
      sbf_ops_pkg::OFS_STATUS: begin
        read_val[0] = (s.fsm != sbf_ops_pkg::ST_IDLE);
        read_val[1] = s.decode_miss;
        read_val[2] = s.last_taken;
      end
      sbf_ops_pkg::OFS_ST0: begin
        read_val[$bits(sbf_ops_pkg::status_word_zero_t)-1:0] = s.st0;
      end
      sbf_ops_pkg::OFS_ST1: begin
        read_val[$bits(sbf_ops_pkg::status_word_one_t)-1:0] = s.st1;
      end
      sbf_ops_pkg::OFS_PC: begin
        read_val[sbf_ops_pkg::PC_W-1:0] = s.pc;
      end
      sbf_ops_pkg::OFS_REPEAT: begin
        read_val[15:0] = s.repeat_count;
      end
      sbf_ops_pkg::OFS_CYCLES: begin
        read_val[sbf_ops_pkg::CNT_W-1:0] = s.last_cycles;
      end
      default: begin
        if (is_aux_addr(AVS_ADDRESS)) begin
          read_val = s.aux_register[aux_index(AVS_ADDRESS)];
        end
      end
    endcase
  end

  // --------------------------------------------------------------
  // Branch condition
  // --------------------------------------------------------------

  always_comb begin
    case (op_hi[1:0])
      sbf_ops_pkg::COND_EQUAL: begin
        cond_true = s.st0.zero_flag;
      end
      sbf_ops_pkg::COND_NOT_EQUAL: begin
        cond_true = !s.st0.zero_flag;
      end
      sbf_ops_pkg::COND_TEST_SET: begin
        cond_true = s.st0.test_flag;
      end
      default: begin
        cond_true = !s.st0.test_flag;
      end
    endcase
  end

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------

  always_comb begin
    next_s = s;
    wait_req = 1'b1;
    cycles = sbf_ops_pkg::CYC_ONE;
    wr_merged = merge_be(read_val, AVS_WRITEDATA, AVS_BYTEENABLE);
    next_s.mem_block_b = block_b_sel(MEM_ADDR, MEM_IS_PROG,
                                     s.st1.block_map_select);
    case (s.fsm)
      sbf_ops_pkg::ST_IDLE: begin
        if (AVS_WRITE && AVS_ADDRESS == sbf_ops_pkg::OFS_OPCODE) begin
          wait_req = 1'b0;
          next_s.decode_miss = 1'b0;
          next_s.last_taken = 1'b0;
          if ((op_hi & sbf_ops_pkg::SBF_MASK) == sbf_ops_pkg::SBF_HI &&
              s.st1.object_code_mode) begin
            cycles = sbf_ops_pkg::CYC_SBF;
            next_s.last_taken = cond_true;
            if (cond_true) begin
              next_s.pc = s.pc + sext_offset(op_lo);
            end else begin
              next_s.pc = s.pc + 1'b1;
            end
          end else if (op_hi == sbf_ops_pkg::AUX_REG_SUBTRACT_OP_HI) begin
            next_s.aux_register[s.st1.aux_pointer_select] =
              s.aux_register[s.st1.aux_pointer_select] -
              {{(sbf_ops_pkg::AUX_W-8){1'b0}}, op_lo};
            next_s.pc = s.pc + 1'b1;
          end else if (op_hi == sbf_ops_pkg::SET_STATUS_BITS_OP_HI) begin
            next_s.st0[3:0] = s.st0[3:0] | op_lo[3:0];
            next_s.st1[3:0] = s.st1[3:0] | op_lo[7:4];
            if (op_lo[sbf_ops_pkg::MASK_GLOBAL_IRQ_MASK] ||
                op_lo[sbf_ops_pkg::MASK_DEBUG_EVENT_MASK]) begin
              cycles = sbf_ops_pkg::CYC_TWO;
            end
            next_s.pc = s.pc + 1'b1;
          end else if (opcode == sbf_ops_pkg::OP_SET_BLOCK_MAP) begin
            next_s.st1.block_map_select = 1'b1;
            cycles = sbf_ops_pkg::CYC_MODE;
            next_s.pc = s.pc + 1'b1;
          end else if (opcode == sbf_ops_pkg::OP_SET_OBJ_MODE) begin
            next_s.st1.object_code_mode = 1'b1;
            cycles = sbf_ops_pkg::CYC_MODE;
            next_s.pc = s.pc + 1'b1;
          end else if (opcode == sbf_ops_pkg::OP_SET_EXT_FLAG) begin
            next_s.st1.external_flag_output = 1'b1;
            next_s.pc = s.pc + 1'b1;
          end else begin
            // Opcodes outside the group set decode_miss and leave the CPU registers alone.
            next_s.decode_miss = 1'b1;
          end
          if (!next_s.decode_miss) begin
            next_s.repeat_count = '0;
          end
          next_s.last_cycles = cycles;
          if (cycles != sbf_ops_pkg::CYC_ONE) begin
            next_s.fsm = sbf_ops_pkg::ST_EXEC;
            next_s.count = cycles - sbf_ops_pkg::CYC_ONE;
          end
        end else if (AVS_WRITE) begin
          wait_req = 1'b0;
          case (AVS_ADDRESS)
            sbf_ops_pkg::OFS_ST0: begin
              next_s.st0 = wr_merged[$bits(sbf_ops_pkg::status_word_zero_t)-1:0];
            end
            sbf_ops_pkg::OFS_ST1: begin
              next_s.st1 = wr_merged[$bits(sbf_ops_pkg::status_word_one_t)-1:0];
            end
            sbf_ops_pkg::OFS_PC: begin
              next_s.pc = wr_merged[sbf_ops_pkg::PC_W-1:0];
            end
            sbf_ops_pkg::OFS_REPEAT: begin
              next_s.repeat_count = wr_merged[15:0];
            end
            default: begin
              if (is_aux_addr(AVS_ADDRESS)) begin
                next_s.aux_register[aux_index(AVS_ADDRESS)] = wr_merged;
              end
            end
          endcase
        end else if (AVS_READ) begin
          // Read data is captured first so that the bus sees a flop.
          next_s.rdata = read_val;
          next_s.fsm = sbf_ops_pkg::ST_READ;
        end
      end
      sbf_ops_pkg::ST_READ: begin
        wait_req = 1'b0;
        next_s.fsm = sbf_ops_pkg::ST_IDLE;
      end
      sbf_ops_pkg::ST_EXEC: begin
        // The bus is stalled while a multi-cycle instruction retires.
        next_s.count = s.count - sbf_ops_pkg::CYC_ONE;
        if (s.count == sbf_ops_pkg::CYC_ONE) begin
          next_s.fsm = sbf_ops_pkg::ST_IDLE;
        end
      end
      default: begin
        next_s.fsm = sbf_ops_pkg::ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------
  // Registers and outputs
  // --------------------------------------------------------------

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s <= sbf_ops_pkg::STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign AVS_WAITREQUEST = wait_req;
  assign AVS_READDATA = s.rdata;
  assign EXT_FLAG_OUT = s.st1.external_flag_output;
  assign MEM_BLOCK_B = s.mem_block_b;

endmodule : short_branch_and_status_set_ops

//--- verif/bus_master_model.sv
/*
  Avalon-MM master standing in for the fetch path: issues register accesses.
  Assumes a slave with waitrequest; only the bench's timeout ends a wait.
*/
`timescale 1ns/1ps
module bus_master_model (
  input wire logic clk,
  input wire logic wait_req,
  input wire logic [31:0] rdata,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] wdata,
  output logic [3:0] be
);
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    wdata = 32'h0000_0000;
    be = 4'hF;
  end

  // The request is judged only at rising edges; data is taken at the edge that ends the wait.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    address <= a;
    wdata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (wait_req !== 1'b0);
    q = rdata;
    read <= 1'b0;
    write <= 1'b0;
    // Released lines show the inverse so a stale value cannot pass for a fresh one.
    wdata <= ~d;
    address <= ~a;
    @(posedge clk);
  endtask : xfer
endmodule : bus_master_model

//--- verif/status_ops_checker_asserts.sv
/*
  Checker on the top ports of the branch and status block.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module status_ops_checker (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic EXT_FLAG_OUT,
  input wire logic [sbf_ops_pkg::MEM_ADDR_W-1:0] MEM_ADDR,
  input wire logic MEM_IS_PROG,
  input wire logic MEM_BLOCK_B
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic acc;
  logic obj;
  logic [15:0] op;
  assign acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h00;
  assign op = AVS_WRITEDATA[15:0];
  // Object mode is mirrored here because fast branch timing depends on it.
  always_ff @(posedge CLK)
    if (!RSTN) obj <= 1'b0;
    else if (acc && op == 16'h561F) obj <= 1'b1;
    else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h0C && AVS_BYTEENABLE[0]) obj <= AVS_WRITEDATA[4];

  branch_len_a: assert property (acc && op[15:10] == 6'h3B && obj |=> AVS_WAITREQUEST [*3])
    else $error("fast branch shorter than four cycles");
  mask_long_a: assert property (acc && op[15:8] == 8'h3B && op[5:4] != 2'b00 |=> AVS_WAITREQUEST)
    else $error("mask set with interrupt or debug bit took one cycle");
  mode_len_a: assert property (acc && (op == 16'h561A || op == 16'h561F) |=> AVS_WAITREQUEST [*4])
    else $error("mode set shorter than five cycles");
  flag_set_a: assert property (acc && op == 16'h5626 |=> EXT_FLAG_OUT)
    else $error("flag pin not high after flag set");
  flag_cause_a: assert property ($rose(EXT_FLAG_OUT) |-> $past(AVS_WRITE) && !$past(AVS_WAITREQUEST))
    else $error("flag pin rose without a write");
  flag_hold_a: assert property ($fell(EXT_FLAG_OUT) |-> $past(AVS_WRITE))
    else $error("flag pin fell without a write");
  data_map_a: assert property (!MEM_IS_PROG |=> MEM_BLOCK_B == $past(MEM_ADDR[10]))
    else $error("data space block select wrong");
  read_first_a: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST)
    else $error("read answered in its first cycle");
  read_bound_a: assert property (AVS_READ |-> ##[0:6] !AVS_WAITREQUEST)
    else $error("read not answered in time");
  cover property (acc && op[15:10] == 6'h3B && obj);
  cover property (acc && op == 16'h561A);
  cover property ($rose(EXT_FLAG_OUT));
endmodule : status_ops_checker

bind short_branch_and_status_set_ops status_ops_checker chk_u (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_FLAG_OUT(EXT_FLAG_OUT),
  .MEM_ADDR(MEM_ADDR), .MEM_IS_PROG(MEM_IS_PROG), .MEM_BLOCK_B(MEM_BLOCK_B));

//--- verif/short_branch_and_status_set_ops_tb.sv
/*
  Self-checking bench for the branch and status block.
  Assumes the bus master model and the bound checker.
*/
`timescale 1ns/1ps
module short_branch_and_status_set_ops_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic read, write, wait_req, ext_flag, mem_b;
  logic [7:0] address;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [sbf_ops_pkg::MEM_ADDR_W-1:0] mem_addr = 11'h000;
  logic mem_prog = 1'b0;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  bus_master_model bm_u (.clk(clk), .wait_req(wait_req), .rdata(rdata), .address(address), .read(read),
    .write(write), .wdata(wdata), .be(be));
  short_branch_and_status_set_ops dut_u (.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(address), .AVS_READ(read),
    .AVS_WRITE(write), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .EXT_FLAG_OUT(ext_flag), .MEM_ADDR(mem_addr), .MEM_IS_PROG(mem_prog),
    .MEM_BLOCK_B(mem_b));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bm_u.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bm_u.xfer(1'b0, a, 32'h0000_0000, q);
    n_tests++;
    if (q !== e) begin
      miscompares++;
      $display("BAD reg %h expected %h seen %h", a, e, q);
    end
  endtask : chk
  task automatic chk_pin(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : chk_pin
  task automatic probe(input logic [10:0] a, input logic p, input logic e);
    mem_addr <= a;
    mem_prog <= p;
    @(posedge clk);
    @(negedge clk);
    chk_pin("block", e, mem_b);
    @(posedge clk);
  endtask : probe

  task automatic t_reset();
    chk(8'h08, 32'h0000_0000);
    chk(8'h0C, 32'h0000_0000);
    wr(8'h00, 32'h0000_EC05);
    chk(8'h04, 32'h0000_0002);
    chk(8'h10, 32'h0000_0000);
    $display("reset and miss test done");
  endtask : t_reset
  task automatic t_branch();
    logic [7:0] ofs;
    logic [31:0] st;
    wr(8'h00, 32'h0000_561F);
    chk(8'h18, 32'h0000_0005);
    chk(8'h0C, 32'h0000_0010);
    for (int i = 0; i < 8; i++) begin
      ofs = i[2] ? 8'h7F : 8'h80;
      st = (i[2] ^ i[0]) ? 32'h0000_0010 : 32'h0000_0004;
      wr(8'h08, st);
      wr(8'h10, 32'h0000_0100);
      wr(8'h14, 32'h0000_0005);
      wr(8'h00, {16'h0000, 6'h3B, i[2:1], ofs});
      chk(8'h10, (i[0] ^ i[1]) ? 32'h0000_0100 + {{24{ofs[7]}}, ofs} : 32'h0000_0101);
      chk(8'h18, 32'h0000_0004);
      chk(8'h04, (i[0] ^ i[1]) ? 32'h0000_0004 : 32'h0000_0000);
      chk(8'h14, 32'h0000_0000);
      chk(8'h08, st);
    end
    $display("branch test done");
  endtask : t_branch
  task automatic t_aux();
    wr(8'h0C, 32'h0000_0290);
    wr(8'h30, 32'h0000_0007);
    wr(8'h34, 32'h0000_0010);
    wr(8'h14, 32'h0000_0003);
    wr(8'h00, 32'h0000_FD20);
    chk(8'h34, 32'hFFFF_FFF0);
    chk(8'h30, 32'h0000_0007);
    chk(8'h18, 32'h0000_0001);
    chk(8'h14, 32'h0000_0000);
    $display("aux test done");
  endtask : t_aux
  task automatic t_mask();
    for (int i = 0; i < 8; i++) begin
      wr(8'h08, 32'h0000_0010);
      wr(8'h0C, 32'h0000_0010);
      wr(8'h00, 32'h0000_3B00 | (32'h0000_0001 << i));
      chk(8'h08, 32'h0000_0010 | (i < 4 ? 32'h0000_0001 << i : 32'h0000_0000));
      chk(8'h0C, 32'h0000_0010 | (i < 4 ? 32'h0000_0000 : 32'h0000_0001 << (i - 4)));
      chk(8'h18, (i == 4 || i == 5) ? 32'h0000_0002 : 32'h0000_0001);
    end
    $display("mask test done");
  endtask : t_mask
  task automatic t_modes();
    wr(8'h0C, 32'h0000_0010);
    probe(11'h005, 1'b1, 1'b1);
    probe(11'h405, 1'b0, 1'b1);
    wr(8'h00, 32'h0000_561A);
    chk(8'h18, 32'h0000_0005);
    probe(11'h005, 1'b1, 1'b0);
    chk_pin("flag", 1'b0, ext_flag);
    wr(8'h00, 32'h0000_5626);
    @(negedge clk);
    chk_pin("flag", 1'b1, ext_flag);
    @(posedge clk);
    chk(8'h0C, 32'h0000_0070);
    chk(8'h18, 32'h0000_0001);
    $display("mode test done");
  endtask : t_modes

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_branch();
    t_aux();
    t_mask();
    t_modes();
    close_out();
  end
endmodule : short_branch_and_status_set_ops_tb
